// >>> logic/sbd_modulator.sv
// Purpose: digital model of a single-bit second-order modulator output stage
// Assumes: core_clk is the modulator clock; samples arrive through a fifo
// Notes:   fault inputs override clipping, clipping overrides the loop
`timescale 1ns/1ps

// How it works
// - stream is linear only within clipping magnitude
// - low clip: zeros, one 1 per 128
// - high clip: ones, one 0 per 128
// - supply loss holds output constantly low
// - common-mode overvoltage holds output constantly high
// - supply loss wins over common-mode overvoltage
// - second-order noise shaping on one-bit quantizer
// - output updates on each rising clock edge
// - ones density proportional, half at zero
module sbd_modulator #(
    parameter int SAMPLE_W    = sbd_pkg::SAMPLE_W,
    parameter int FIFO_DEPTH  = sbd_pkg::FIFO_DEPTH,
    parameter int HOLD_CYCLES = sbd_pkg::HOLD_CYCLES
) (
    input  wire logic                core_clk,
    input  wire logic                sys_rst,
    input  wire logic [SAMPLE_W-1:0] sample_data,
    input  wire logic                sample_valid,
    output logic                     sample_ready,
    input  wire logic                high_side_supply_ok,
    input  wire logic                cm_overvoltage,
    output logic                     bit_stream_out,
    output logic                     clip_active,
    output logic                     fail_active
);
    localparam int HOLD_W = $clog2(HOLD_CYCLES + 1);
    localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HOLD_CYCLES - 1);
    localparam int IW = sbd_pkg::INTEG_W;
    localparam logic signed [IW-1:0] FB_POS = IW'(sbd_pkg::CLIP_CODE);
    localparam logic signed [IW-1:0] FB_NEG = -FB_POS;

    // ------------------------------------------------------------------
    // sample buffer
    // ------------------------------------------------------------------
    sbd_fifo_if #(.WIDTH(SAMPLE_W)) smp_if ();

    sbd_fifo #(
        .WIDTH (SAMPLE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .port_if  (smp_if)
    );

    assign smp_if.in_valid = sample_valid;
    assign smp_if.in_data  = sample_data;
    assign sample_ready    = smp_if.in_ready;

    // ------------------------------------------------------------------
    // sample pacing: one new input every HOLD_CYCLES clocks
    // ------------------------------------------------------------------
    logic [HOLD_W-1:0]          hold_cnt_ff, nxt_hold_cnt;
    logic signed [SAMPLE_W-1:0] x_ff,        nxt_x;
    logic                       hold_tick;

    assign hold_tick        = (hold_cnt_ff == HOLD_LAST);
    assign smp_if.out_ready = hold_tick;

    always_comb begin
        nxt_hold_cnt = hold_tick ? '0 : hold_cnt_ff + 1'b1;
        nxt_x        = x_ff;
        if (hold_tick && smp_if.out_valid) begin
            nxt_x = smp_if.out_data;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hold_cnt_ff <= '0;
            x_ff        <= '0;
        end else begin
            hold_cnt_ff <= nxt_hold_cnt;
            x_ff        <= nxt_x;
        end
    end

    // ------------------------------------------------------------------
    // mode selection
    // ------------------------------------------------------------------
    sbd_pkg::sbd_mode_e mode_ff, nxt_mode;
    logic signed [IW-1:0] x_ext;
    logic                 x_lo;
    logic                 x_hi;

    assign x_ext = IW'(x_ff);
    assign x_lo  = (x_ext <= FB_NEG);
    assign x_hi  = (x_ext >= FB_POS);

    always_comb begin
        if (!high_side_supply_ok) begin
            nxt_mode = sbd_pkg::SBD_FAIL_LO;
        end else if (cm_overvoltage) begin
            nxt_mode = sbd_pkg::SBD_FAIL_HI;
        end else if (x_lo) begin
            nxt_mode = sbd_pkg::SBD_CLIP_LO;
        end else if (x_hi) begin
            nxt_mode = sbd_pkg::SBD_CLIP_HI;
        end else begin
            nxt_mode = sbd_pkg::SBD_LINEAR;
        end
    end

    // ------------------------------------------------------------------
    // second-order loop and output bit
    // ------------------------------------------------------------------
    logic signed [IW-1:0]           integ1_ff, nxt_integ1;
    logic signed [IW-1:0]           integ2_ff, nxt_integ2;
    logic [sbd_pkg::CLIP_CNT_W-1:0] clip_cnt_ff, nxt_clip_cnt;
    logic [sbd_pkg::CLIP_CNT_W-1:0] clip_cnt_cur;
    logic                           bit_ff, nxt_bit;
    logic signed [IW-1:0]           fb;

    assign fb = bit_ff ? FB_POS : FB_NEG;

    always_comb begin
        nxt_integ1   = integ1_ff;
        nxt_integ2   = integ2_ff;
        nxt_bit      = bit_ff;
        // entry bit is position zero, so the first run is not one bit long
        clip_cnt_cur = (nxt_mode != mode_ff) ? sbd_pkg::CLIP_CNT_ZERO : clip_cnt_ff;
        nxt_clip_cnt = (clip_cnt_cur == sbd_pkg::CLIP_CNT_LAST) ? sbd_pkg::CLIP_CNT_ZERO
                                                                : clip_cnt_cur + 1'b1;
        unique case (nxt_mode)
            sbd_pkg::SBD_LINEAR: begin
                // two integrators with one-bit feedback
                nxt_integ1 = integ1_ff + x_ext - fb;
                nxt_integ2 = integ2_ff + nxt_integ1 - fb;
                nxt_bit    = (nxt_integ2 >= 0);
            end
            sbd_pkg::SBD_CLIP_LO: begin
                nxt_bit = (clip_cnt_cur == sbd_pkg::CLIP_CNT_LAST);
            end
            sbd_pkg::SBD_CLIP_HI: begin
                nxt_bit = (clip_cnt_cur != sbd_pkg::CLIP_CNT_LAST);
            end
            sbd_pkg::SBD_FAIL_LO: begin
                nxt_bit    = 1'b0;
                nxt_integ1 = '0;
                nxt_integ2 = '0;
            end
            sbd_pkg::SBD_FAIL_HI: begin
                nxt_bit    = 1'b1;
                nxt_integ1 = '0;
                nxt_integ2 = '0;
            end
        endcase
    end

    // output registered on the rising clock edge
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_ff     <= sbd_pkg::SBD_LINEAR;
            integ1_ff   <= '0;
            integ2_ff   <= '0;
            clip_cnt_ff <= '0;
            bit_ff      <= sbd_pkg::BIT_RESET;
        end else begin
            mode_ff     <= nxt_mode;
            integ1_ff   <= nxt_integ1;
            integ2_ff   <= nxt_integ2;
            clip_cnt_ff <= nxt_clip_cnt;
            bit_ff      <= nxt_bit;
        end
    end

    assign bit_stream_out = bit_ff;
    assign clip_active    = (mode_ff == sbd_pkg::SBD_CLIP_LO) || (mode_ff == sbd_pkg::SBD_CLIP_HI);
    assign fail_active    = (mode_ff == sbd_pkg::SBD_FAIL_LO) || (mode_ff == sbd_pkg::SBD_FAIL_HI);

endmodule : sbd_modulator

// >>> inc/sbd_pkg.sv
// Purpose: shared constants and types of the single-bit modulator block
// Assumes: input samples are signed codes of LSB_UV microvolts each
// Notes:   the clipping code is derived from the clipping voltage and the code weight
package sbd_pkg;

    // ------------------------------------------------------------------
    // clock
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 25000;

    // ------------------------------------------------------------------
    // input scaling
    // ------------------------------------------------------------------
    localparam int SAMPLE_W  = 16;
    localparam int VCLIP_MV  = 320;
    localparam int LSB_UV    = 10;
    localparam int UV_PER_MV = 1000;
    localparam int CLIP_CODE = (VCLIP_MV * UV_PER_MV) / LSB_UV;

    // ------------------------------------------------------------------
    // loop filter and clipping pattern
    // ------------------------------------------------------------------
    localparam int INTEG_W     = 28;
    localparam int CLIP_PERIOD = 128;
    localparam int CLIP_CNT_W  = $clog2(CLIP_PERIOD);
    localparam int HOLD_CYCLES = 16;
    localparam int FIFO_DEPTH  = 16;

    localparam logic [CLIP_CNT_W-1:0] CLIP_CNT_LAST = CLIP_CNT_W'(CLIP_PERIOD - 1);
    localparam logic [CLIP_CNT_W-1:0] CLIP_CNT_ZERO = '0;
    localparam logic                  BIT_RESET     = 1'h0;

    // ------------------------------------------------------------------
    // output modes
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        SBD_LINEAR  = 5'h01,
        SBD_CLIP_LO = 5'h02,
        SBD_CLIP_HI = 5'h04,
        SBD_FAIL_LO = 5'h08,
        SBD_FAIL_HI = 5'h10
    } sbd_mode_e;

endpackage : sbd_pkg

// >>> inc/sbd_fifo_if.sv
// Purpose: valid/ready carrier between the sample fifo and the modulator
// Assumes: one clock domain
// Notes:   push side and pop side each have their own handshake
`timescale 1ns/1ps
interface sbd_fifo_if #(
    parameter int WIDTH = 16
);
    logic             in_valid;
    logic             in_ready;
    logic [WIDTH-1:0] in_data;
    logic             out_valid;
    logic             out_ready;
    logic [WIDTH-1:0] out_data;

    modport fifo (
        input  in_valid,
        output in_ready,
        input  in_data,
        output out_valid,
        input  out_ready,
        output out_data
    );

    modport user (
        output in_valid,
        input  in_ready,
        output in_data,
        input  out_valid,
        output out_ready,
        input  out_data
    );
endinterface : sbd_fifo_if

// >>> logic/sbd_fifo.sv
// Purpose: sample buffer with registered head word
// Assumes: one clock, asynchronous active-high reset
// Notes:   DEPTH words in the array plus one in the output register
`timescale 1ns/1ps
module sbd_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic core_clk,
    input  wire logic sys_rst,
    sbd_fifo_if.fifo  port_if
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PTR_W-1:0] wr_ptr_ff,  nxt_wr_ptr;
    logic [PTR_W-1:0] rd_ptr_ff,  nxt_rd_ptr;
    logic [CNT_W-1:0] cnt_ff,     nxt_cnt;
    logic             head_vld_ff, nxt_head_vld;
    logic [WIDTH-1:0] head_ff,    nxt_head;
    logic             push;
    logic             load;

    // ------------------------------------------------------------------
    // handshake and pointers
    // ------------------------------------------------------------------
    assign port_if.in_ready  = (cnt_ff != CNT_FULL);
    assign port_if.out_valid = head_vld_ff;
    assign port_if.out_data  = head_ff;

    always_comb begin
        push = port_if.in_valid && port_if.in_ready;
        load = (cnt_ff != '0) && (!head_vld_ff || port_if.out_ready);
        nxt_wr_ptr   = wr_ptr_ff;
        nxt_rd_ptr   = rd_ptr_ff;
        nxt_cnt      = cnt_ff;
        nxt_head     = head_ff;
        nxt_head_vld = head_vld_ff;
        if (push) begin
            nxt_wr_ptr = (wr_ptr_ff == PTR_LAST) ? '0 : wr_ptr_ff + 1'b1;
        end
        if (load) begin
            nxt_rd_ptr   = (rd_ptr_ff == PTR_LAST) ? '0 : rd_ptr_ff + 1'b1;
            nxt_head     = mem_ff[rd_ptr_ff];
            nxt_head_vld = 1'b1;
        end else if (port_if.out_ready) begin
            nxt_head_vld = 1'b0;
        end
        nxt_cnt = cnt_ff + CNT_W'(push) - CNT_W'(load);
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr_ff   <= '0;
            rd_ptr_ff   <= '0;
            cnt_ff      <= '0;
            head_ff     <= '0;
            head_vld_ff <= 1'b0;
        end else begin
            wr_ptr_ff   <= nxt_wr_ptr;
            rd_ptr_ff   <= nxt_rd_ptr;
            cnt_ff      <= nxt_cnt;
            head_ff     <= nxt_head;
            head_vld_ff <= nxt_head_vld;
        end
    end

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= port_if.in_data;
        end
    end

endmodule : sbd_fifo

// >>> test/sbd_modulator_props.sv
// Purpose: concurrent checks on the modulator output stream and status flags
// Assumes: one clock domain, asynchronous active-high reset
// Notes:   run and clip-age counters saturate at 255
`timescale 1ns/1ps
module sbd_modulator_chk #(
    parameter int SAMPLE_W = sbd_pkg::SAMPLE_W
) (
    input wire logic                core_clk,
    input wire logic                sys_rst,
    input wire logic [SAMPLE_W-1:0] sample_data,
    input wire logic                sample_valid,
    input wire logic                sample_ready,
    input wire logic                high_side_supply_ok,
    input wire logic                cm_overvoltage,
    input wire logic                bit_stream_out,
    input wire logic                clip_active,
    input wire logic                fail_active
);
    // ------------------------------------------------------------------
    // helper counters
    // ------------------------------------------------------------------
    logic [7:0] run_ff, nxt_run, age_ff, nxt_age;
    logic       last_ff;
    logic       steady;

    always_comb begin
        nxt_run = (bit_stream_out != last_ff) ? 8'h01 :
                  ((run_ff == 8'hff) ? run_ff : run_ff + 8'h01);
        nxt_age = !clip_active ? 8'h00 : ((age_ff == 8'hff) ? age_ff : age_ff + 8'h01);
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            run_ff  <= 8'h00;
            age_ff  <= 8'h00;
            last_ff <= 1'h0;
        end else begin
            run_ff  <= nxt_run;
            age_ff  <= nxt_age;
            last_ff <= bit_stream_out;
        end
    end

    assign steady = clip_active && (age_ff >= 8'hc8);

    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    AST_SUPPLY_LOW: assert property (!high_side_supply_ok |=> !bit_stream_out)
        else $error("stream not low after supply loss");
    AST_CM_HIGH: assert property (high_side_supply_ok && cm_overvoltage |=> bit_stream_out)
        else $error("stream not high on common-mode overvoltage");
    AST_PRIO: assert property (!high_side_supply_ok && cm_overvoltage |=> !bit_stream_out && fail_active)
        else $error("supply loss did not take precedence");
    AST_FAIL_FLAG: assert property (!high_side_supply_ok || cm_overvoltage |=> fail_active && !clip_active)
        else $error("fail flag not raised");
    AST_RECOVER: assert property (high_side_supply_ok && !cm_overvoltage |=> !fail_active)
        else $error("fail flag stuck");
    AST_NO_PULSE: assert property ((!high_side_supply_ok)[*3] |-> $stable(bit_stream_out) && !clip_active)
        else $error("opposite bit during supply loss");
    AST_CLIP_RUN: assert property (steady |-> run_ff <= 8'h7f)
        else $error("clip run longer than 127 bits");
    AST_CLIP_SINGLE: assert property (steady && run_ff == 8'h7f |=> run_ff == 8'h01 ##1 run_ff == 8'h01 ##1 run_ff == 8'h02)
        else $error("clip opposite bit not single");

    COV_CLIP: cover property (steady && run_ff == 8'h7f);
    COV_SUP: cover property (!high_side_supply_ok && cm_overvoltage);
    COV_FULL: cover property (sample_valid && !sample_ready);
endmodule : sbd_modulator_chk

bind sbd_modulator sbd_modulator_chk #(.SAMPLE_W(SAMPLE_W)) u_chk (
    .core_clk(core_clk), .sys_rst(sys_rst), .sample_data(sample_data),
    .sample_valid(sample_valid), .sample_ready(sample_ready),
    .high_side_supply_ok(high_side_supply_ok), .cm_overvoltage(cm_overvoltage),
    .bit_stream_out(bit_stream_out), .clip_active(clip_active), .fail_active(fail_active));

// >>> test/sbd_rx_model.sv
// Purpose: receiving logic: window sum, cubed-sinc decimator, constant-run fault flags
// Assumes: bit stream sampled on each rising core_clk edge
// Notes:   word is the signed sum of +-1 per bit over one decimation window
`timescale 1ns/1ps
module sbd_rx_model #(
    parameter int DEC_RATIO = 256,
    parameter int OUT_W     = 16
) (
    input  wire logic core_clk,
    input  wire logic sys_rst,
    input  wire logic bit_in,
    output int        word,
    output int        sinc_word,
    output logic      word_valid,
    output logic      sup_fault,
    output logic      cm_fault
);
    localparam int FULL_W = 3 * $clog2(DEC_RATIO);
    localparam int SHIFT  = FULL_W + 1 - OUT_W;
    int     sum, n, run;
    longint acc1, acc2, acc3, dly1, dly2, dly3, dif1, dif2, dif3;
    logic   last;

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            {sum, n, run} = '0;
            {acc1, acc2, acc3, dly1, dly2, dly3} = '0;
            last = 1'b0;
            {word, sinc_word} <= '0;
            {word_valid, sup_fault, cm_fault} <= 3'h0;
        end else begin
            sum = sum + (bit_in ? 1 : -1);
            acc1 = acc1 + (bit_in ? 1 : -1);
            acc2 = acc2 + acc1;
            acc3 = acc3 + acc2;
            n = n + 1;
            word_valid <= (n == DEC_RATIO);
            if (n == DEC_RATIO) begin
                word <= sum;
                dif1 = acc3 - dly1;
                dly1 = acc3;
                dif2 = dif1 - dly2;
                dly2 = dif1;
                dif3 = dif2 - dly3;
                dly3 = dif2;
                sinc_word <= int'(dif3 >>> SHIFT);
                sum = 0;
                n = 0;
            end
            run = (bit_in == last) ? run + 1 : 1;
            last = bit_in;
            sup_fault <= (run > 128) && !bit_in;
            cm_fault <= (run > 128) && bit_in;
        end
    end
endmodule : sbd_rx_model

// >>> test/sbd_tb.sv
// Purpose: self-checking bench for the modulator stream, clipping and fail-safe
// Assumes: 40 MHz core_clk, receiving model on the stream
// Notes:   first words after an input change are discarded while settling
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin err_total++; \
    $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module tb;
    logic        core_clk, sys_rst, sample_valid, supply_ok, cm_ov;
    logic [15:0] sample_data;
    logic        sample_ready, bit_out, clip_active, fail_active, word_valid, sup_f, cm_f;
    int          word, sinc_w, err_total, n_checks, cyc;

    sbd_modulator dut (.core_clk(core_clk), .sys_rst(sys_rst), .sample_data(sample_data),
        .sample_valid(sample_valid), .sample_ready(sample_ready),
        .high_side_supply_ok(supply_ok), .cm_overvoltage(cm_ov), .bit_stream_out(bit_out),
        .clip_active(clip_active), .fail_active(fail_active));
    sbd_rx_model u_rx (.core_clk(core_clk), .sys_rst(sys_rst), .bit_in(bit_out),
        .word(word), .sinc_word(sinc_w), .word_valid(word_valid), .sup_fault(sup_f),
        .cm_fault(cm_f));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 15000) begin
            err_total++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : test_done

    task automatic push(input logic [15:0] d);
        logic r;
        sample_valid <= 1'b1;
        sample_data  <= d;
        do begin
            @(negedge core_clk);
            r = sample_ready;
            @(posedge core_clk);
        end while (!r);
        sample_valid <= 1'b0;
    endtask : push

    task automatic get_word(output int w, output int s);
        repeat (4) begin
            do @(negedge core_clk); while (word_valid !== 1'b1);
        end
        w = word;
        s = sinc_w;
    endtask : get_word

    task automatic t_linear(input logic [15:0] d, input int exp_sum);
        int w;
        int s;
        int e;
        e = int'($signed(d)) * (1 << 15) / sbd_pkg::CLIP_CODE;
        push(d);
        get_word(w, s);
        `CHK("lin_word_ok", 1'b1, (w >= exp_sum - 8) && (w <= exp_sum + 8))
        `CHK("lin_sinc_ok", 1'b1, (s >= e - 256) && (s <= e + 256))
        `CHK("lin_clip", 1'b0, clip_active)
        @(posedge core_clk);
    endtask : t_linear

    task automatic t_clip(input logic [15:0] d, input logic maj);
        int ones;
        push(d);
        repeat (300) @(posedge core_clk);
        ones = 0;
        repeat (256) begin
            @(negedge core_clk);
            ones += bit_out;
        end
        `CHK("clip_ones", maj ? 254 : 2, ones)
        `CHK("clip_flag", 2'b10, {clip_active, fail_active})
        `CHK("clip_rx_flags", 2'b00, {sup_f, cm_f})
        @(posedge core_clk);
    endtask : t_clip

    task automatic t_fail(input logic s, input logic c, input logic lvl);
        int ones;
        supply_ok <= s;
        cm_ov     <= c;
        repeat (150) @(posedge core_clk);
        ones = 0;
        repeat (140) begin
            @(negedge core_clk);
            ones += bit_out;
        end
        `CHK("fail_ones", lvl ? 140 : 0, ones)
        `CHK("fail_flag", 2'b01, {clip_active, fail_active})
        `CHK("fail_rx", {!lvl, lvl}, {sup_f, cm_f})
        @(posedge core_clk);
        supply_ok <= 1'b1;
        cm_ov     <= 1'b0;
        repeat (300) @(posedge core_clk);
        `CHK("fail_clear", 3'b000, {fail_active, sup_f, cm_f})
    endtask : t_fail

    task automatic t_fill();
        int acc;
        logic r;
        acc = 0;
        sample_valid <= 1'b1;
        sample_data  <= 16'h0000;
        do begin
            @(negedge core_clk);
            r = sample_ready;
            @(posedge core_clk);
            acc += r;
        end while (r && acc < 40);
        sample_valid <= 1'b0;
        `CHK("fill_refused", 1'b1, (acc >= 16) && (acc <= 18))
        repeat (320) @(posedge core_clk);
        @(negedge core_clk);
        `CHK("drain_ready", 1'b1, sample_ready)
    endtask : t_fill

    initial begin
        {sample_valid, cm_ov, err_total, n_checks, cyc} = '0;
        sample_data = 16'h0000;
        supply_ok   = 1'b1;
        sys_rst     = 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(negedge core_clk);
        `CHK("rst_out", 4'h1, {bit_out, clip_active, fail_active, sample_ready})
        @(posedge core_clk);
        t_linear(16'h0000, 0);
        t_linear(16'h3e80, 128);
        t_clip(16'h8300, 1'b0);
        t_clip(16'h7d00, 1'b1);
        t_clip(16'h8000, 1'b0);
        t_linear(16'h0000, 0);
        t_fail(1'b0, 1'b0, 1'b0);
        t_fail(1'b1, 1'b1, 1'b1);
        t_fail(1'b0, 1'b1, 1'b0);
        t_fill();
        test_done();
    end
endmodule : tb
